// ---- hw/ser_rx_pkg.sv ----
package ser_rx_pkg;
  // register byte offsets on the peripheral bus
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_RXDATA = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 24;
  localparam int CNT_W = 6;
  // status bit positions
  localparam int ST_IF0 = 0;
  localparam int ST_IF1 = 1;
  localparam int ST_TFS = 2;
  localparam int ST_RFS = 3;
  localparam int ST_ROE = 5;
  localparam int ST_RDF = 7;
  localparam int ST_W = 8;
  // control bit positions
  localparam int CT_RX_ON = 0;
  localparam int CT_NETWORK = 1;
  localparam int CT_SHARED_CLK = 2;
  localparam int CT_TX_ONE_EN = 3;
  localparam int CT_TX_TWO_EN = 4;
  localparam int CT_CTL0_DIR = 5;
  localparam int CT_CTL1_DIR = 6;
  localparam int CT_PFS0 = 7;
  localparam int CT_PFS1 = 8;
  localparam int CT_LSB_FIRST = 9;
  localparam int CT_WL_LO = 10;
  localparam int CT_WL_HI = 12;
  localparam int CT_W = 13;
  localparam logic [CT_W-1:0] CTRL_RESET = 13'h0000;
  // interrupt event bit positions
  localparam int EV_WORD = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_FRAME = 2;
  localparam int EV_W = 3;
  // word length codes
  localparam logic [2:0] WL_8 = 3'h0;
  localparam logic [2:0] WL_12 = 3'h1;
  localparam logic [2:0] WL_16 = 3'h2;
  localparam logic [2:0] WL_24 = 3'h3;
  localparam logic [2:0] WL_32 = 3'h4;
  localparam logic [CNT_W-1:0] BITS_8 = 6'h08;
  localparam logic [CNT_W-1:0] BITS_12 = 6'h0c;
  localparam logic [CNT_W-1:0] BITS_16 = 6'h10;
  localparam logic [CNT_W-1:0] BITS_24 = 6'h18;
  localparam logic [CNT_W-1:0] BITS_32 = 6'h20;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_SHIFT = 1'b1
  } rx_state_t;
endpackage : ser_rx_pkg

// ---- hw/ser_rx_status.sv ----
`timescale 1ns/1ps
// What this block does
// - set receive frame sync flag when sync arrived during the shifted word
// - network mode clears receive frame sync flag for a word without sync
// - receive frame sync flag is only meaningful while the receiver is on
// - normal mode reads receive frame sync flag as one
// - normal mode reads transmit frame sync flag as one while transmitting
// - sample control pin one on first bit after frame sync, hold pending
// - copy pending pin one sample into input flag one at word transfer
// - input flag one works only with pin function, shared clock, tx two off, input
// - latch control pin zero on first bit, load flag zero at transfer
// - input flag zero works only with pin function, shared clock, tx one off, input
// - 24-bit shift register shifts on bit clock from frame sync until the word completes
// - msb first when lsb-first control clear, lsb first when set
// - transfer to receive data after 8, 12, 16, 24 or 32 bit clocks
// - receive full set on transfer, cleared by reading receive data
// - overrun set when a word completes while receive full still set
module ser_rx_status
  import ser_rx_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [DATA_W-1:0] PWDATA_IN,
  output logic [DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  input wire logic BIT_CLK_IN,
  input wire logic FRAME_SYNC_IN,
  input wire logic RX_DATA_IN,
  input wire logic CTL_PIN_0_IN,
  input wire logic CTL_PIN_1_IN
);

  function automatic logic [CNT_W-1:0] word_bits(input logic [2:0] code);
    case (code)
      WL_8: word_bits = BITS_8;
      WL_12: word_bits = BITS_12;
      WL_16: word_bits = BITS_16;
      WL_24: word_bits = BITS_24;
      WL_32: word_bits = BITS_32;
      default: word_bits = BITS_8;
    endcase
  endfunction : word_bits

  // two-stage synchronisers; only the second stage is read by logic
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic clk_prev_r;
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      clk_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {CTL_PIN_1_IN, CTL_PIN_0_IN, RX_DATA_IN, FRAME_SYNC_IN, BIT_CLK_IN};
      pin_s2_r <= pin_s1_r;
      clk_prev_r <= pin_s2_r[0];
    end
  end

  logic bclk_rise;
  logic fs;
  logic din;
  logic ctl0;
  logic ctl1;
  assign bclk_rise = pin_s2_r[0] & ~clk_prev_r;
  assign fs = pin_s2_r[1];
  assign din = pin_s2_r[2];
  assign ctl0 = pin_s2_r[3];
  assign ctl1 = pin_s2_r[4];

  rx_state_t state_r, state_nxt;
  logic [WORD_W-1:0] shift_r, shift_nxt;
  logic [WORD_W-1:0] rx_data_r, rx_data_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CT_W-1:0] ctrl_r, ctrl_nxt;
  logic fs_seen_r, fs_seen_nxt;
  logic pend0_r, pend0_nxt;
  logic pend1_r, pend1_nxt;
  logic rfs_r, rfs_nxt;
  logic tfs_r, tfs_nxt;
  logic if0_r, if0_nxt;
  logic if1_r, if1_nxt;
  logic rdf_r, rdf_nxt;
  logic roe_r, roe_nxt;
  logic roe_seen_r, roe_seen_nxt;
  logic [EV_W-1:0] ev_stat_r, ev_stat_nxt;
  logic [EV_W-1:0] ev_en_r, ev_en_nxt;
  logic irq_r, irq_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [DATA_W-1:0] prdata_r, prdata_nxt;

  logic network;
  logic if0_ok;
  logic if1_ok;
  logic [ST_W-1:0] status_view;
  logic mapped;
  logic done;
  logic [WORD_W-1:0] shifted;
  logic first_bit;
  logic word_end;
  logic [EV_W-1:0] ev_set;

  assign network = ctrl_r[CT_NETWORK];
  assign if0_ok = ctrl_r[CT_PFS0] & ctrl_r[CT_SHARED_CLK] & ~ctrl_r[CT_TX_ONE_EN]
    & ~ctrl_r[CT_CTL0_DIR];
  assign if1_ok = ctrl_r[CT_PFS1] & ctrl_r[CT_SHARED_CLK] & ~ctrl_r[CT_TX_TWO_EN]
    & ~ctrl_r[CT_CTL1_DIR];
  assign mapped = (PADDR_IN == OFF_STATUS) | (PADDR_IN == OFF_RXDATA)
    | (PADDR_IN == OFF_CTRL) | (PADDR_IN == OFF_IRQ_STAT)
    | (PADDR_IN == OFF_IRQ_EN) | (PADDR_IN == OFF_IRQ_CLR);
  assign done = PSEL_IN & PENABLE_IN & pready_r;

  always_comb begin
    status_view = '0;
    status_view[ST_RDF] = rdf_r;
    status_view[ST_ROE] = roe_r;
    // rfs is left as last computed while the receiver is off
    status_view[ST_RFS] = network ? rfs_r : 1'b1;
    status_view[ST_TFS] = network ? tfs_r
      : (ctrl_r[CT_TX_ONE_EN] | ctrl_r[CT_TX_TWO_EN]);
    status_view[ST_IF0] = if0_r & if0_ok;
    status_view[ST_IF1] = if1_r & if1_ok;
  end

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    rx_data_nxt = rx_data_r;
    cnt_nxt = cnt_r;
    ctrl_nxt = ctrl_r;
    fs_seen_nxt = fs_seen_r;
    pend0_nxt = pend0_r;
    pend1_nxt = pend1_r;
    rfs_nxt = rfs_r;
    tfs_nxt = tfs_r;
    if0_nxt = if0_r;
    if1_nxt = if1_r;
    rdf_nxt = rdf_r;
    roe_nxt = roe_r;
    roe_seen_nxt = roe_seen_r;
    ev_en_nxt = ev_en_r;
    ev_set = '0;
    first_bit = 1'b0;
    word_end = 1'b0;
    shifted = ctrl_r[CT_LSB_FIRST] ? {din, shift_r[WORD_W-1:1]}
      : {shift_r[WORD_W-2:0], din};

    // receive path: one bit per rising bit clock edge
    if (!ctrl_r[CT_RX_ON]) begin
      state_nxt = RX_IDLE;
      cnt_nxt = CNT_ZERO;
    end else if (bclk_rise) begin
      case (state_r)
        RX_IDLE: begin
          if (fs) begin
            first_bit = 1'b1;
            state_nxt = RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (cnt_r == CNT_ZERO) begin
            first_bit = 1'b1;
          end
        end
        default: state_nxt = RX_IDLE;
      endcase
      if (first_bit) begin
        // clean start: no stale bits of the last word in a short one
        shift_nxt = ctrl_r[CT_LSB_FIRST] ? {din, {(WORD_W-1){1'b0}}}
          : {{(WORD_W-1){1'b0}}, din};
        cnt_nxt = CNT_ONE;
        fs_seen_nxt = fs;
        tfs_nxt = fs;
        pend0_nxt = ctl0;
        pend1_nxt = ctl1;
        ev_set[EV_FRAME] = fs;
      end else if (state_r == RX_SHIFT) begin
        shift_nxt = shifted;
        cnt_nxt = cnt_r + CNT_ONE;
        fs_seen_nxt = fs_seen_r | fs;
        if (cnt_r + CNT_ONE == word_bits(ctrl_r[CT_WL_HI:CT_WL_LO])) begin
          word_end = 1'b1;
          cnt_nxt = CNT_ZERO;
          // normal mode waits for the next sync; network runs slot after slot
          state_nxt = network ? RX_SHIFT : RX_IDLE;
        end
      end
    end

    // bus side effects first so that hardware sets below win
    if (done && !PWRITE_IN) begin
      if (PADDR_IN == OFF_STATUS && roe_r) begin
        roe_seen_nxt = 1'b1;
      end
      if (PADDR_IN == OFF_RXDATA) begin
        rdf_nxt = 1'b0;
        if (roe_seen_r) begin
          roe_nxt = 1'b0;
          roe_seen_nxt = 1'b0;
        end
      end
    end
    if (done && PWRITE_IN) begin
      if (PADDR_IN == OFF_CTRL) begin
        ctrl_nxt = PWDATA_IN[CT_W-1:0];
      end
      if (PADDR_IN == OFF_IRQ_EN) begin
        ev_en_nxt = PWDATA_IN[EV_W-1:0];
      end
    end

    if (word_end) begin
      rx_data_nxt = shifted;
      ev_set[EV_WORD] = 1'b1;
      if (rdf_r) begin
        roe_nxt = 1'b1;
        ev_set[EV_OVERRUN] = 1'b1;
      end
      rdf_nxt = 1'b1;
      rfs_nxt = fs_seen_r | fs;
      if0_nxt = pend0_r;
      if1_nxt = pend1_r;
    end

    ev_stat_nxt = ev_stat_r;
    if (done && PWRITE_IN && PADDR_IN == OFF_IRQ_CLR) begin
      ev_stat_nxt = ev_stat_r & ~PWDATA_IN[EV_W-1:0];
    end
    ev_stat_nxt = ev_stat_nxt | ev_set;
    irq_nxt = |(ev_stat_nxt & ev_en_nxt);

    // one wait state: answer registered in the first access cycle
    pready_nxt = PSEL_IN & PENABLE_IN & ~pready_r;
    pslverr_nxt = pready_nxt & ~mapped;
    prdata_nxt = prdata_r;
    if (pready_nxt) begin
      prdata_nxt = '0;
      if (!PWRITE_IN) begin
        case (PADDR_IN)
          OFF_STATUS: prdata_nxt[ST_W-1:0] = status_view;
          OFF_RXDATA: prdata_nxt[WORD_W-1:0] = rx_data_r;
          OFF_CTRL: prdata_nxt[CT_W-1:0] = ctrl_r;
          OFF_IRQ_STAT: prdata_nxt[EV_W-1:0] = ev_stat_r;
          OFF_IRQ_EN: prdata_nxt[EV_W-1:0] = ev_en_r;
          default: prdata_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= RX_IDLE;
      shift_r <= '0;
      rx_data_r <= '0;
      cnt_r <= CNT_ZERO;
      ctrl_r <= CTRL_RESET;
      fs_seen_r <= 1'b0;
      pend0_r <= 1'b0;
      pend1_r <= 1'b0;
      rfs_r <= 1'b0;
      tfs_r <= 1'b0;
      if0_r <= 1'b0;
      if1_r <= 1'b0;
      rdf_r <= 1'b0;
      roe_r <= 1'b0;
      roe_seen_r <= 1'b0;
      ev_stat_r <= '0;
      ev_en_r <= '0;
      irq_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      rx_data_r <= rx_data_nxt;
      cnt_r <= cnt_nxt;
      ctrl_r <= ctrl_nxt;
      fs_seen_r <= fs_seen_nxt;
      pend0_r <= pend0_nxt;
      pend1_r <= pend1_nxt;
      rfs_r <= rfs_nxt;
      tfs_r <= tfs_nxt;
      if0_r <= if0_nxt;
      if1_r <= if1_nxt;
      rdf_r <= rdf_nxt;
      roe_r <= roe_nxt;
      roe_seen_r <= roe_seen_nxt;
      ev_stat_r <= ev_stat_nxt;
      ev_en_r <= ev_en_nxt;
      irq_r <= irq_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
  assign IRQ_OUT = irq_r;
endmodule : ser_rx_status

// ---- sim/ser_codec_model.sv ----
`timescale 1ns/1ps
module ser_codec_model (
  output logic BIT_CLK_OUT,
  output logic FRAME_SYNC_OUT,
  output logic DATA_OUT
);
  initial begin
    BIT_CLK_OUT = 1'b0;
    FRAME_SYNC_OUT = 1'b0;
    DATA_OUT = 1'b0;
  end
  // clock stands still between words; odd offset keeps phase unrelated
  task automatic send(input logic [31:0] w, input int n, input bit lsb, input int nsync);
    int k;
    #37;
    for (k = 0; k < n; k++) begin
      DATA_OUT = lsb ? w[k] : w[n-1-k];
      FRAME_SYNC_OUT = (k < nsync);
      #200 BIT_CLK_OUT = 1'b1;
      #200 BIT_CLK_OUT = 1'b0;
    end
    FRAME_SYNC_OUT = 1'b0;
    DATA_OUT = ~DATA_OUT; // released line shows no stale bit
  endtask : send
endmodule : ser_codec_model

// ---- sim/ser_rx_props_properties.sv ----
`timescale 1ns/1ps
module ser_rx_props
  import ser_rx_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [DATA_W-1:0] PWDATA_IN,
  input wire logic [DATA_W-1:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic IRQ_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  wire logic rd_done = PREADY_OUT && !PWRITE_IN;
  wire logic wr_done = PREADY_OUT && PWRITE_IN;
  sequence s_setup; PSEL_IN && !PENABLE_IN; endsequence
  sequence s_acc; PSEL_IN && PENABLE_IN; endsequence
  property p_wait; s_setup ##1 s_acc |-> !PREADY_OUT ##1 PREADY_OUT; endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait state");
  property p_pulse; $rose(PREADY_OUT) |=> !PREADY_OUT; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_in_acc; PREADY_OUT |-> s_acc; endproperty
  a_in_acc: assert property (p_in_acc) else $error("ready outside access phase");
  property p_unmap; rd_done && PADDR_IN > OFF_IRQ_CLR |-> PSLVERR_OUT && PRDATA_OUT == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_mapped; PREADY_OUT && PADDR_IN <= OFF_IRQ_CLR && PADDR_IN[1:0] == 2'h0
    |-> !PSLVERR_OUT; endproperty
  a_mapped: assert property (p_mapped) else $error("error on mapped address");
  property p_stat; rd_done && PADDR_IN == OFF_STATUS
    |-> PRDATA_OUT[31:8] == 24'h0 && !PRDATA_OUT[6] && !PRDATA_OUT[4]; endproperty
  a_stat: assert property (p_stat) else $error("status reserved bits set");
  property p_rxw; rd_done && PADDR_IN == OFF_RXDATA |-> PRDATA_OUT[31:24] == 8'h0; endproperty
  a_rxw: assert property (p_rxw) else $error("receive data wider than word");
  property p_clr; wr_done && PADDR_IN == OFF_IRQ_CLR && PWDATA_IN[2:0] == 3'h7
    |-> ##2 !IRQ_OUT; endproperty
  a_clr: assert property (p_clr) else $error("interrupt stays after clear");
  property p_mask; wr_done && PADDR_IN == OFF_IRQ_EN && PWDATA_IN[2:0] == 3'h0
    |-> ##2 !IRQ_OUT; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt still high");
endmodule : ser_rx_props
bind ser_rx_status ser_rx_props i_ser_rx_props (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT));

// ---- sim/tb_ser_rx_status.sv ----
`timescale 1ns/1ps
module tb_ser_rx_status;
  import ser_rx_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, p0 = 0, p1 = 0;
  logic [7:0] pa = 8'h0;
  logic [31:0] pwd = 32'h0, prd;
  logic prdy, perr, irq, bck, fs, rxd;
  logic [40:0] expq[$];
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  int nb[5] = '{8, 12, 16, 24, 32};
  always #25 clk = ~clk;
  ser_rx_status i_ser_rx_status (.CLOCK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .IRQ_OUT(irq), .BIT_CLK_IN(bck), .FRAME_SYNC_IN(fs),
    .RX_DATA_IN(rxd), .CTL_PIN_0_IN(p0), .CTL_PIN_1_IN(p1));
  ser_codec_model i_ser_codec_model (.BIT_CLK_OUT(bck), .FRAME_SYNC_OUT(fs), .DATA_OUT(rxd));
  task automatic check(input string nm, input logic [40:0] seen, input logic [40:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (psel && pen && prdy === 1'b1 && !pwr) check("read", {pa, perr, prd}, expq.pop_front());
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    {psel, pen} <= 2'h0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back({a, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // fixed settle covers pin synchronisers plus the transfer cycle
  task automatic xfer(input logic [31:0] w, input int n, input bit lsb, input int ns);
    i_ser_codec_model.send(w, n, lsb, ns);
    repeat (8) @(posedge clk);
  endtask : xfer
  initial begin
    int i;
    logic g;
    logic [31:0] w, w2, ct, m;
    logic [7:0] fl;
    void'($urandom(62973));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, OFF_STATUS, 32'hffffffff);
    rd(OFF_STATUS, 33'h8);
    rd(OFF_CTRL, 33'h0);
    rd(8'h18, 33'h100000000);
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    for (i = 0; i < 5; i++) begin
      g = (i == 4);
      w = $urandom;
      {p1, p0} <= 2'($urandom);
      ct = 32'h185 | (32'(i) << 10);
      if (i == 3) ct[9] = 1'b1;
      if (g) ct[4:3] = 2'h3;
      apb(1'b1, OFF_CTRL, ct);
      xfer(w, nb[i], i == 3, nb[i]);
      check("irq", 41'(irq), 41'h1);
      if (i == 0) begin
        apb(1'b1, OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk);
        check("irq masked", 41'(irq), 41'h0);
        apb(1'b1, OFF_IRQ_EN, 32'h1);
      end
      rd(OFF_IRQ_STAT, 33'h5);
      apb(1'b1, OFF_IRQ_CLR, 32'h7);
      fl = {5'h0, g, ~g & p1, ~g & p0};
      m = (nb[i] >= 24) ? 32'hffffff : (32'h1 << nb[i]) - 32'h1;
      rd(OFF_STATUS, {25'h0, 8'h88 | fl});
      rd(OFF_RXDATA, {1'b0, w & m});
      rd(OFF_STATUS, {25'h0, 8'h08 | fl});
    end
    apb(1'b1, OFF_CTRL, 32'h0);
    xfer($urandom, 8, 1'b0, 8);
    rd(OFF_STATUS, {25'h0, 8'h08});
    rd(OFF_RXDATA, {1'b0, w & 32'hffffff});
    apb(1'b1, OFF_CTRL, 32'h1c03);
    w = $urandom;
    w2 = $urandom;
    xfer(w, 8, 1'b0, 1);
    rd(OFF_STATUS, {25'h0, 8'h8c});
    xfer(w2, 8, 1'b0, 0);
    rd(OFF_IRQ_STAT, 33'h7);
    rd(OFF_STATUS, {25'h0, 8'ha0});
    rd(OFF_RXDATA, {25'h0, w2[7:0]});
    rd(OFF_STATUS, 33'h0);
    // let the monitor take the last read before the verdict
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : tb_ser_rx_status
